// ---- logic/pfcreg_defines.vh ----
// Behaviour
// - input power reads as 5-bit exponent from config bits 2:0 and 11-bit mantissa
// - code 0x98 reads a fixed 8-bit bus revision value
// - code 0x99 reads a fixed 8-bit maker identifier
// - code 0x9a reads a fixed 8-bit model number
// - code 0x9b reads a fixed 8-bit maker revision
// - codes 0xb0 to 0xbf are block read and write data commands
// - block command page equals command code minus 0xb0
// - code 0xd1 reads the checksum of the latest nvm download
// - code 0xd2 holds the byte count returned by block reads
// - code 0xd3 holds the 16-bit start offset within the selected page
// - write to 0xd4 erases the selected page, only while unlocked
// - pages zero and one erase only in manufacturing test mode
// - correct key at 0xd5 unlocks; same register changes the key
// - trim key written twice unlocks trim; other value relocks
// - block read at 0xf1 returns maker data from nvm
// - action 00 only cuts the present pwm pulse short
// - action 01 counts cycles, shuts down, restarts after programmed delay
// - action 10 cuts pulses, shuts down, waits for power-on request
// - action 11 disables pwm after count until the flag is cleared
// - count field 00/01/10/11 allows 1/2/4/8 cycles; bits 3:0 reserved
`ifndef PFCREG_DEFINES_VH
`define PFCREG_DEFINES_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define PFC_CMD_PIN 16'h0097
`define PFC_CMD_BUSREV 16'h0098
`define PFC_CMD_MKID 16'h0099
`define PFC_CMD_MODEL 16'h009a
`define PFC_CMD_MKREV 16'h009b
`define PFC_CMD_SSDLY 16'h005c
`define PFC_CMD_BLK_FIRST 16'h00b0
`define PFC_CMD_BLK_LAST 16'h00bf
`define PFC_CMD_CRC 16'h00d1
`define PFC_CMD_NBYTES 16'h00d2
`define PFC_CMD_OFFSET 16'h00d3
`define PFC_CMD_ERASE 16'h00d4
`define PFC_CMD_NVMKEY 16'h00d5
`define PFC_CMD_TRIMKEY 16'h00d6
`define PFC_CMD_MKDATA 16'h00f1
`define PFC_CMD_OCP 16'hfe00
`define PFC_CMD_EXPCFG 16'hfe39

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define PFC_OCP_ACT_HI 7
`define PFC_OCP_ACT_LO 6
`define PFC_OCP_CNT_HI 5
`define PFC_OCP_CNT_LO 4
`define PFC_OCP_RST 8'h00
`define PFC_EXP_RST 3'h0
`define PFC_SSDLY_RST 3'h0
`define PFC_NBYTES_RST 8'h20
`define PFC_OFFSET_RST 16'h0000
`define PFC_TRIM_KEY 8'h00
`define PFC_NVMKEY_RST 8'h5a
`define PFC_MKDATA_PAGE 5'h10
`define PFC_PROT_PAGES 5'h02

// ----------------------------------------
// timing
// ----------------------------------------
`define PFC_CLK_NS 100
`define PFC_ERASE_WAIT_MS 35
`define PFC_SSDLY_UNIT_CYC 16'h2710 // 1 ms step at the 100 ns clock

`endif

// ---- logic/pfcreg_top.v ----
`timescale 1ns/1ps
`include "pfcreg_defines.vh"

module pfcreg_top #(
   // identity values below are arbitrary
   parameter [7:0] BUS_REV = 8'h11,
   parameter [7:0] MAKER_ID = 8'h3c,
   parameter [7:0] MODEL_NUM = 8'h27,
   parameter [7:0] MAKER_REV = 8'h01,
   // soft start delay step, in clock cycles
   parameter [15:0] SSDLY_UNIT_CYC = `PFC_SSDLY_UNIT_CYC
)(
   input wire mclk_i,                // device clock, 10 MHz
   input wire rst_i,                 // synchronous reset, high
   input wire cmd_valid_i,           // command request strobe
   input wire cmd_write_i,           // 1 = write, 0 = read
   input wire [15:0] cmd_code_i,     // command code
   input wire [15:0] cmd_wdata_i,    // write data, bytes in low bits
   output reg rd_valid_o,            // read data valid pulse
   output reg [15:0] rd_data_o,      // read data
   output reg cmd_nack_o,            // refused command pulse
   input wire [10:0] pin_mantissa_i, // metered input power mantissa
   input wire [7:0] nvm_crc_i,       // download checksum
   input wire nvm_crc_valid_i,       // download done strobe
   input wire mfg_test_i,            // manufacturing test mode
   output reg nvm_wr_o,              // nvm byte write pulse
   output reg nvm_rd_o,              // nvm byte read pulse
   output reg [4:0] nvm_page_o,      // nvm page
   output reg [15:0] nvm_addr_o,     // byte address inside page
   output reg [7:0] nvm_wdata_o,     // nvm write byte
   input wire [7:0] nvm_rdata_i,     // nvm byte, valid while rd is high
   output reg nvm_erase_o,           // page erase pulse
   output wire nvm_unlocked_o,       // nvm unlocked level
   output wire trim_unlocked_o,      // trim writes allowed level
   output wire [7:0] nvm_rd_len_o,   // bytes per block read
   input wire sw_clk_i,              // switching cycle clock pin
   input wire fast_oc_i,             // fast overcurrent comparator pin
   input wire power_on_request_i,    // power-on request pin
   input wire fault_clear_i,         // clears latched fault
   output wire pwm_cut_o,            // end present pwm pulse
   output wire pwm_disable_o,        // pwm output disabled
   output reg soft_start_o,          // soft start request pulse
   output wire ocp_fault_o           // overcurrent fault flag
);

   // ----------------------------------------
   // state codes
   // ----------------------------------------
   localparam [1:0] ST_RUN = 2'b00;
   localparam [1:0] ST_RETRY = 2'b01;
   localparam [1:0] ST_WAIT_PON = 2'b10;
   localparam [1:0] ST_LATCH = 2'b11;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // block data command range test
   function is_blk;
      input [15:0] code;
      begin
         is_blk = (code >= `PFC_CMD_BLK_FIRST) &&
                  (code <= `PFC_CMD_BLK_LAST);
      end
   endfunction

   // 3-flop filter: accept a change once stages two and three agree
   function filt;
      input s2;
      input s3;
      input prev;
      begin
         filt = (s2 == s3) ? s3 : prev;
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] ocp_cfg_r;
   reg [2:0] exp_cfg_r;
   reg [2:0] ssdly_r;
   reg [7:0] nbytes_r;
   reg [15:0] offset_r;
   reg [15:0] ptr_r;
   reg [4:0] page_sel_r;
   reg [7:0] crc_r;
   reg [7:0] nvm_key_r;
   reg nvm_unl_r;
   reg [1:0] trim_cnt_r;
   reg rd_pend_r;
   reg [1:0] st_r;
   reg [3:0] oc_cnt_r;
   reg oc_seen_r;
   reg [18:0] dly_r;
   reg [2:0] sw_s_r;
   reg [2:0] oc_s_r;
   reg [2:0] pon_s_r;
   reg sw_f_r;
   reg oc_f_r;
   reg pon_f_r;
   wire wr;
   wire rd;
   wire [4:0] blk_page;
   wire [3:0] oc_limit;
   wire sw_rise;
   wire [18:0] dly_total;

   assign wr = cmd_valid_i & cmd_write_i;
   assign rd = cmd_valid_i & ~cmd_write_i;
   // page = code minus first block code
   // page from code
   assign blk_page = {1'b0, cmd_code_i[3:0]};
   assign nvm_unlocked_o = nvm_unl_r;
   assign trim_unlocked_o = (trim_cnt_r == 2'd2);
   assign nvm_rd_len_o = nbytes_r;

   // ----------------------------------------
   // configuration writes
   // ----------------------------------------
   // reserved ocp bits 3:0 are never stored
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ocp_cfg_r <= `PFC_OCP_RST;
         exp_cfg_r <= `PFC_EXP_RST;
         ssdly_r <= `PFC_SSDLY_RST;
         nbytes_r <= `PFC_NBYTES_RST;
         offset_r <= `PFC_OFFSET_RST;
      end
      else if (wr)
      begin
         if (cmd_code_i == `PFC_CMD_OCP)
            ocp_cfg_r <= {cmd_wdata_i[7:4], 4'h0};
         else if (cmd_code_i == `PFC_CMD_EXPCFG)
            exp_cfg_r <= cmd_wdata_i[2:0];
         else if (cmd_code_i == `PFC_CMD_SSDLY)
            ssdly_r <= cmd_wdata_i[2:0];
         else if (cmd_code_i == `PFC_CMD_NBYTES)
            nbytes_r <= cmd_wdata_i[7:0];
         else if (cmd_code_i == `PFC_CMD_OFFSET)
            offset_r <= cmd_wdata_i;
      end
   end

   // ----------------------------------------
   // checksum capture
   // ----------------------------------------
   always @(posedge mclk_i)
   begin
      if (rst_i)
         crc_r <= 8'h00;
      else if (nvm_crc_valid_i)
         crc_r <= nvm_crc_i;
   end

   // ----------------------------------------
   // nvm and trim keys
   // ----------------------------------------
   // key change only from the unlocked state, so a guess cannot reset it
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         nvm_key_r <= `PFC_NVMKEY_RST;
         nvm_unl_r <= 1'b0;
         trim_cnt_r <= 2'd0;
      end
      else if (wr)
      begin
         if (cmd_code_i == `PFC_CMD_NVMKEY)
         begin
            if (cmd_wdata_i[7:0] == nvm_key_r)
               nvm_unl_r <= 1'b1;
            else if (nvm_unl_r)
               nvm_key_r <= cmd_wdata_i[7:0];
         end
         if (cmd_code_i == `PFC_CMD_TRIMKEY)
         begin
            if (cmd_wdata_i[7:0] != `PFC_TRIM_KEY)
               trim_cnt_r <= 2'd0;
            else if (trim_cnt_r != 2'd2)
               trim_cnt_r <= trim_cnt_r + 2'd1;
         end
         else
            trim_cnt_r <= (trim_cnt_r == 2'd2) ? 2'd2 : 2'd0;
      end
   end

   // ----------------------------------------
   // nvm access sequencing
   // ----------------------------------------
   // the pointer walks from the offset; writing the offset restarts it
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         ptr_r <= `PFC_OFFSET_RST;
         page_sel_r <= 5'h00;
         nvm_wr_o <= 1'b0;
         nvm_rd_o <= 1'b0;
         nvm_erase_o <= 1'b0;
         nvm_page_o <= 5'h00;
         nvm_addr_o <= 16'h0000;
         nvm_wdata_o <= 8'h00;
      end
      else
      begin
         nvm_wr_o <= 1'b0;
         nvm_rd_o <= 1'b0;
         nvm_erase_o <= 1'b0;
         if (wr && cmd_code_i == `PFC_CMD_OFFSET)
            ptr_r <= cmd_wdata_i;
         else if (cmd_valid_i && is_blk(cmd_code_i))
         begin
            if (blk_page != page_sel_r)
               ptr_r <= offset_r + 16'd1;
            else
               ptr_r <= ptr_r + 16'd1;
            page_sel_r <= blk_page;
            nvm_page_o <= blk_page;
            nvm_addr_o <= (blk_page != page_sel_r) ? offset_r : ptr_r;
            nvm_wdata_o <= cmd_wdata_i[7:0];
            nvm_wr_o <= cmd_write_i & nvm_unl_r;
            nvm_rd_o <= ~cmd_write_i;
         end
         else if (rd && cmd_code_i == `PFC_CMD_MKDATA)
         begin
            ptr_r <= ptr_r + 16'd1;
            nvm_page_o <= `PFC_MKDATA_PAGE;
            nvm_addr_o <= ptr_r;
            nvm_rd_o <= 1'b1;
         end
         else if (wr && cmd_code_i == `PFC_CMD_ERASE)
         begin
            nvm_page_o <= page_sel_r;
            nvm_erase_o <= nvm_unl_r &&
               (mfg_test_i || page_sel_r >= `PFC_PROT_PAGES);
         end
      end
   end

   // ----------------------------------------
   // read answers
   // ----------------------------------------
   // nvm reads answer one cycle later, register reads at once
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         rd_valid_o <= 1'b0;
         rd_data_o <= 16'h0000;
         cmd_nack_o <= 1'b0;
         rd_pend_r <= 1'b0;
      end
      else
      begin
         rd_valid_o <= 1'b0;
         cmd_nack_o <= 1'b0;
         rd_pend_r <= 1'b0;
         if (rd_pend_r)
         begin
            rd_valid_o <= 1'b1;
            rd_data_o <= {8'h00, nvm_rdata_i};
         end
         else if (rd)
         begin
            rd_valid_o <= 1'b1;
            if (cmd_code_i == `PFC_CMD_PIN)
               rd_data_o <= {{2{exp_cfg_r[2]}}, exp_cfg_r,
                             pin_mantissa_i};
            else if (cmd_code_i == `PFC_CMD_BUSREV)
               rd_data_o <= {8'h00, BUS_REV};
            else if (cmd_code_i == `PFC_CMD_MKID)
               rd_data_o <= {8'h00, MAKER_ID};
            else if (cmd_code_i == `PFC_CMD_MODEL)
               rd_data_o <= {8'h00, MODEL_NUM};
            else if (cmd_code_i == `PFC_CMD_MKREV)
               rd_data_o <= {8'h00, MAKER_REV};
            else if (cmd_code_i == `PFC_CMD_CRC)
               rd_data_o <= {8'h00, crc_r};
            else if (cmd_code_i == `PFC_CMD_NBYTES)
               rd_data_o <= {8'h00, nbytes_r};
            else if (cmd_code_i == `PFC_CMD_OFFSET)
               rd_data_o <= offset_r;
            else if (cmd_code_i == `PFC_CMD_OCP)
               rd_data_o <= {8'h00, ocp_cfg_r};
            else if (cmd_code_i == `PFC_CMD_EXPCFG)
               rd_data_o <= {13'h0000, exp_cfg_r};
            else if (cmd_code_i == `PFC_CMD_SSDLY)
               rd_data_o <= {13'h0000, ssdly_r};
            else if (is_blk(cmd_code_i) ||
                     cmd_code_i == `PFC_CMD_MKDATA)
            begin
               rd_valid_o <= 1'b0;
               rd_pend_r <= 1'b1;
            end
            else
            begin
               // write-only and unmapped codes
               rd_valid_o <= 1'b0;
               cmd_nack_o <= 1'b1;
               rd_data_o <= 16'h0000;
            end
         end
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         sw_s_r <= 3'b000;
         oc_s_r <= 3'b000;
         pon_s_r <= 3'b000;
         sw_f_r <= 1'b0;
         oc_f_r <= 1'b0;
         pon_f_r <= 1'b0;
      end
      else
      begin
         sw_s_r <= {sw_s_r[1:0], sw_clk_i};
         oc_s_r <= {oc_s_r[1:0], fast_oc_i};
         pon_s_r <= {pon_s_r[1:0], power_on_request_i};
         sw_f_r <= filt(sw_s_r[1], sw_s_r[2], sw_f_r);
         oc_f_r <= filt(oc_s_r[1], oc_s_r[2], oc_f_r);
         pon_f_r <= filt(pon_s_r[1], pon_s_r[2], pon_f_r);
      end
   end

   assign sw_rise = filt(sw_s_r[1], sw_s_r[2], sw_f_r) & ~sw_f_r;

   // ----------------------------------------
   // fast overcurrent response
   // ----------------------------------------
   // cycle allowance decode
   assign oc_limit = 4'd1 << ocp_cfg_r[`PFC_OCP_CNT_HI:`PFC_OCP_CNT_LO];
   assign dly_total = {16'h0000, ssdly_r} * {3'b000, SSDLY_UNIT_CYC};
   assign pwm_cut_o = oc_f_r;
   assign pwm_disable_o = (st_r != ST_RUN);
   assign ocp_fault_o = (st_r == ST_LATCH);

   // cycles count only while consecutive ones carry an overcurrent
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         st_r <= ST_RUN;
         oc_cnt_r <= 4'd0;
         oc_seen_r <= 1'b0;
         dly_r <= 19'd0;
         soft_start_o <= 1'b0;
      end
      else
      begin
         soft_start_o <= 1'b0;
         case (st_r)
            ST_RUN:
            begin
               if (sw_rise)
                  oc_seen_r <= oc_f_r;
               else if (oc_f_r)
                  oc_seen_r <= 1'b1;
               if (sw_rise)
               begin
                  if (!(oc_seen_r | oc_f_r))
                     oc_cnt_r <= 4'd0;
                  else if (oc_cnt_r + 4'd1 >= oc_limit &&
                           ocp_cfg_r[7:6] != 2'b00)
                  begin
                     oc_cnt_r <= 4'd0;
                     dly_r <= 19'd0;
                     oc_seen_r <= 1'b0; // a restart begins a clean cycle
                     if (ocp_cfg_r[7:6] == 2'b01)
                        st_r <= ST_RETRY;
                     else if (ocp_cfg_r[7:6] == 2'b10)
                        st_r <= ST_WAIT_PON;
                     else
                        st_r <= ST_LATCH;
                  end
                  else if (ocp_cfg_r[7:6] != 2'b00)
                     oc_cnt_r <= oc_cnt_r + 4'd1;
               end
            end
            ST_RETRY:
            begin
               if (dly_r >= dly_total)
               begin
                  st_r <= ST_RUN;
                  soft_start_o <= 1'b1;
               end
               else
                  dly_r <= dly_r + 19'd1;
            end
            ST_WAIT_PON:
            begin
               if (pon_f_r)
               begin
                  st_r <= ST_RUN;
                  soft_start_o <= 1'b1;
               end
            end
            default:
            begin
               if (fault_clear_i)
                  st_r <= ST_RUN;
            end
         endcase
      end
   end

endmodule // pfcreg_top

// ---- dv/pfcreg_chk_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// command port checker
// ----------------------------------------
module pfcreg_chk #(
   parameter [7:0] MAKER_ID = 8'h3c
)(
   input wire mclk_i,                // clock
   input wire rst_i,                 // reset
   input wire cmd_valid_i,           // strobe
   input wire cmd_write_i,           // direction
   input wire [15:0] cmd_code_i,     // code
   input wire [15:0] cmd_wdata_i,    // write data
   input wire rd_valid_o,            // answer
   input wire [15:0] rd_data_o,      // answer data
   input wire cmd_nack_o,            // refusal
   input wire [10:0] pin_mantissa_i, // power mantissa
   input wire mfg_test_i,            // test mode
   input wire nvm_wr_o,              // nvm write
   input wire nvm_rd_o,              // nvm read
   input wire [4:0] nvm_page_o,      // nvm page
   input wire nvm_erase_o,           // nvm erase
   input wire nvm_unlocked_o,        // unlock level
   input wire trim_unlocked_o,       // trim level
   input wire [7:0] nvm_rd_len_o,    // read length
   input wire fault_clear_i,         // fault clear
   input wire ocp_fault_o            // fault flag
);
   // request decode shared by the properties
   wire wr_req = cmd_valid_i && cmd_write_i;
   wire rd_req = cmd_valid_i && !cmd_write_i;
   wire blk = cmd_code_i[15:4] == 12'h00b;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   ident_read_a:
   assert property (rd_req && cmd_code_i == 16'h0099 |=>
      rd_valid_o && rd_data_o[7:0] == MAKER_ID) else $error("maker id");
   wo_nack_a:
   assert property (rd_req && cmd_code_i == 16'h00d5 |=> cmd_nack_o)
      else $error("write-only read not refused");
   block_read_a:
   assert property (rd_req && blk |=> nvm_rd_o &&
      nvm_page_o == {1'b0, $past(cmd_code_i[3:0])} ##1 rd_valid_o)
      else $error("block read page or timing");
   locked_ops_a:
   assert property (wr_req && !nvm_unlocked_o &&
      (blk || cmd_code_i == 16'h00d4) |=> !nvm_wr_o && !nvm_erase_o)
      else $error("locked nvm operation went through");
   erase_guard_a:
   assert property (nvm_erase_o |-> $past(nvm_unlocked_o) &&
      ($past(mfg_test_i) || nvm_page_o >= 5'h02))
      else $error("erase without unlock or of protected page");
   read_len_a:
   assert property (wr_req && cmd_code_i == 16'h00d2 |=>
      nvm_rd_len_o == $past(cmd_wdata_i[7:0])) else $error("read length");
   trim_relock_a:
   assert property (wr_req && cmd_code_i == 16'h00d6 &&
      cmd_wdata_i[7:0] != 8'h00 |=> !trim_unlocked_o)
      else $error("trim not relocked");
   fault_hold_a:
   assert property (ocp_fault_o && !fault_clear_i |=> ocp_fault_o)
      else $error("fault flag dropped without clear");
   power_fmt_a:
   assert property (rd_req && cmd_code_i == 16'h0097 |=>
      rd_data_o[10:0] == $past(pin_mantissa_i)) else $error("mantissa");
endmodule // pfcreg_chk

bind pfcreg_top pfcreg_chk #(.MAKER_ID(MAKER_ID)) u_chk (.*);

// ---- dv/pfcreg_nvm_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// nvm array model
// ----------------------------------------
module pfcreg_nvm_model (
   input wire mclk_i,        // clock
   input wire wr_i,          // byte write
   input wire rd_i,          // byte read
   input wire erase_i,       // page erase
   input wire [4:0] page_i,  // page
   input wire [15:0] addr_i, // byte address
   input wire [7:0] wdata_i, // write byte
   output wire [7:0] rdata_o // read byte
);
   reg [7:0] mem [0:31][0:63];
   integer i;
   integer j;
   initial
   begin
      for (i = 0; i < 32; i++)
         for (j = 0; j < 64; j++)
            mem[i][j] = (i == 16) ? (8'h80 ^ j[7:0]) : 8'hff;
   end
   // only 64 bytes a page kept, enough for the bench offsets
   always @(posedge mclk_i)
   begin
      if (wr_i)
         mem[page_i][addr_i[5:0]] <= wdata_i;
      if (erase_i)
         for (i = 0; i < 64; i++)
            mem[page_i][i] <= 8'hff;
   end
   // byte stands while the strobe is high, for the edge that ends it;
   // inverted otherwise so that a mistimed sample shows
   assign rdata_o = rd_i ? mem[page_i][addr_i[5:0]] :
      ~mem[page_i][addr_i[5:0]];
endmodule // pfcreg_nvm_model

// ---- dv/pfcreg_tb.sv ----
`timescale 1ns/1ps
module testbench;
   reg mclk_i = 0, rst_i = 1, cmd_valid_i = 0, cmd_write_i = 0;
   reg nvm_crc_valid_i = 0, mfg_test_i = 0, sw_clk_i = 0, fast_oc_i = 0;
   reg power_on_request_i = 0, fault_clear_i = 0;
   reg [15:0] cmd_code_i = 0, cmd_wdata_i = 0;
   reg [10:0] pin_mantissa_i = 0;
   reg [7:0] nvm_crc_i = 0;
   wire rd_valid_o, cmd_nack_o, nvm_wr_o, nvm_rd_o, nvm_erase_o;
   wire nvm_unlocked_o, trim_unlocked_o, pwm_cut_o, pwm_disable_o;
   wire soft_start_o, ocp_fault_o;
   wire [15:0] rd_data_o, nvm_addr_o;
   wire [4:0] nvm_page_o;
   wire [7:0] nvm_wdata_o, nvm_rdata_i, nvm_rd_len_o;
   integer err_total = 0, num_checks = 0, cyc = 0;
   integer i, j, k, p, a, n, off, ptr, lastp, unl;
   reg [7:0] ref_mem [0:31][0:63];
   reg [7:0] ids [0:3];
   reg [15:0] rdat, e, m;
   reg nk;

   // identity values are arbitrary; short soft start step for sim
   pfcreg_top #(.BUS_REV(8'h21), .MAKER_ID(8'h4d), .MODEL_NUM(8'h62),
      .MAKER_REV(8'h07), .SSDLY_UNIT_CYC(16'd4)) dut (.*);
   pfcreg_nvm_model u_nvm (.mclk_i(mclk_i), .wr_i(nvm_wr_o),
      .rd_i(nvm_rd_o), .erase_i(nvm_erase_o), .page_i(nvm_page_o),
      .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .rdata_o(nvm_rdata_i));

   initial forever #50 mclk_i = ~mclk_i;
   // hang guard
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         wrap_up;
      end
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", num_checks, err_total);
         if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         num_checks++;
         if (seen !== exp)
         begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge mclk_i) #10;
   endtask
   task wr(input [15:0] c, input [15:0] d);
      begin
         tick(1);
         {cmd_valid_i, cmd_write_i, cmd_code_i, cmd_wdata_i} = {2'b11, c, d};
         tick(1);
         cmd_valid_i = 0;
      end
   endtask
   task rd(input [15:0] c);
      begin
         tick(1);
         {cmd_valid_i, cmd_write_i, cmd_code_i} = {2'b10, c};
         tick(1);
         cmd_valid_i = 0;
         for (k = 0; k < 3 && rd_valid_o !== 1'b1 && cmd_nack_o !== 1'b1; k++)
            tick(1);
         rdat = rd_data_o;
         nk = cmd_nack_o;
         tick(1);
      end
   endtask
   task setoff(input integer o);
      begin
         wr(16'h00d3, o[15:0]);
         off = o;
         lastp = -1;
      end
   endtask
   // one block byte through the reference pointer
   task blk(input w, input integer pg, input [7:0] d);
      begin
         // maker data reads carry on from the block pointer
         if (pg != lastp && pg != 16)
            ptr = off;
         if (pg != 16)
            lastp = pg;
         if (w)
         begin
            wr(16'h00b0 + pg, {8'h00, d});
            chk("wr_pulse", {15'h0, nvm_wr_o}, unl);
            if (unl)
            begin
               chk("wr_page", {11'h0, nvm_page_o}, pg);
               chk("wr_addr", nvm_addr_o, ptr);
               ref_mem[pg][ptr] = d;
            end
         end
         else
         begin
            rd(pg == 16 ? 16'h00f1 : 16'h00b0 + pg);
            chk("rd_byte", rdat, {8'h00, ref_mem[pg][ptr]});
         end
         ptr++;
      end
   endtask
   task swc(input integer want);
      begin
         sw_clk_i = 1;
         tick(4);
         sw_clk_i = 0;
         tick(2);
         if (want >= 0)
            chk("pwm_off", pwm_disable_o, want);
         tick(2);
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      i = $urandom(32'h4ebd3b97);
      {ids[0], ids[1], ids[2], ids[3]} = 32'h214d6207;
      for (i = 0; i < 32; i++)
         for (j = 0; j < 64; j++)
            ref_mem[i][j] = (i == 16) ? 8'h80 ^ j : 8'hff;
      unl = 0;
      tick(4);
      rst_i = 0;
      for (i = 0; i < 4; i++)
      begin
         rd(16'h0098 + i);
         chk("ident", rdat, {8'h00, ids[i]});
      end
      rd(16'h00d2);
      chk("nbytes_rst", rdat, 16'h0020);
      for (i = 4; i < 7; i++)
      begin
         rd(16'h00d0 + i);
         chk("wo_nack", nk, 1);
      end
      $display("test identity done");
      for (i = 0; i < 4; i++)
      begin
         e = $urandom % 8;
         m = $urandom % 2048;
         pin_mantissa_i = m[10:0];
         wr(16'hfe39, e);
         rd(16'h0097);
         chk("power", rdat, {{2{e[2]}}, e[2:0], m[10:0]});
         nvm_crc_i = $urandom;
         nvm_crc_valid_i = 1;
         tick(1);
         nvm_crc_valid_i = 0;
         rd(16'h00d1);
         chk("crc", rdat, {8'h00, nvm_crc_i});
         e = $urandom % 256;
         wr(16'h00d2, e);
         chk("rd_len", nvm_rd_len_o, e);
         setoff($urandom % 32);
         rd(16'h00d3);
         chk("offset", rdat, off);
      end
      $display("test registers done");
      p = 2 + $urandom % 14;
      setoff($urandom % 32);
      blk(1, p, 8'h5a);
      wr(16'h00d5, 16'h005b);
      chk("bad_key", nvm_unlocked_o, 0);
      wr(16'h00d5, 16'h005a);
      unl = 1;
      chk("unlock", nvm_unlocked_o, 1);
      setoff($urandom % 32);
      for (i = 0; i < 4; i++)
         blk(1, p, $urandom);
      setoff(off);
      for (i = 0; i < 5; i++)
         blk(0, p, 0);
      blk(0, (p + 1) % 16, 0);
      blk(0, 16, 0);
      blk(0, 16, 0);
      blk(0, p, 0);
      $display("test block data done");
      wr(16'h00d4, 0);
      chk("erase", nvm_erase_o, 1);
      chk("erase_pg", nvm_page_o, p);
      for (j = 0; j < 64; j++)
         ref_mem[p][j] = 8'hff;
      // host pause after erase, shortened for run length
      tick(50);
      setoff(off);
      blk(0, p, 0);
      blk(0, 1, 0);
      wr(16'h00d4, 0);
      chk("prot_erase", nvm_erase_o, 0);
      mfg_test_i = 1;
      wr(16'h00d4, 0);
      chk("mfg_erase", nvm_erase_o, 1);
      mfg_test_i = 0;
      tick(50);
      rst_i = 1;
      tick(2);
      rst_i = 0;
      unl = 0;
      lastp = -1;
      chk("relocked", nvm_unlocked_o, 0);
      wr(16'h00d4, 0);
      chk("lock_erase", nvm_erase_o, 0);
      $display("test erase done");
      wr(16'h00d6, 0);
      chk("trim_once", trim_unlocked_o, 0);
      wr(16'h00d6, 0);
      chk("trim_open", trim_unlocked_o, 1);
      wr(16'h00d6, 7);
      chk("trim_exit", trim_unlocked_o, 0);
      wr(16'h00d6, 0);
      wr(16'h00d2, 16'h0020);
      wr(16'h00d6, 0);
      chk("trim_split", trim_unlocked_o, 0);
      $display("test trim done");
      wr(16'h005c, 7);
      for (a = 0; a < 4; a++)
      begin
         // a clean cycle under the old action flushes stale overcurrent
         swc(-1);
         n = $urandom % 4;
         wr(16'hfe00, {8'h00, a[1:0], n[1:0], 4'hf});
         rd(16'hfe00);
         chk("ocp_reg", rdat, {8'h00, a[1:0], n[1:0], 4'h0});
         fast_oc_i = 1;
         tick(8);
         for (i = 1; i <= (1 << n); i++)
            swc(a != 0 && i == (1 << n));
         chk("pwm_cut", pwm_cut_o, 1);
         fast_oc_i = 0;
         if (a == 1)
         begin
            for (j = 0; j < 80 && soft_start_o !== 1'b1; j++)
               tick(1);
            chk("soft_start", soft_start_o, 1);
         end
         tick(10);
         chk("pwm_wait", pwm_disable_o, a > 1);
         chk("fault", ocp_fault_o, a == 3);
         {power_on_request_i, fault_clear_i} = 2'b11;
         tick(1);
         fault_clear_i = 0;
         tick(6);
         power_on_request_i = 0;
         chk("pwm_back", pwm_disable_o, 0);
         chk("cut_end", pwm_cut_o, 0);
      end
      $display("test overcurrent done");
      wrap_up;
   end
endmodule // testbench
